// ===== common/asrs_pkg.sv
// asrs_pkg: register map, field positions, reset values and states of
// the serial receiver status block.
// assumes a 32-bit AXI4-Lite register bus and a 40 MHz sys_clk.
`default_nettype none

package asrs_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_RX_DATA = 5'h00;
  localparam logic [4:0] ADDR_RX_STAT = 5'h04;
  localparam logic [4:0] ADDR_BAUD = 5'h08;
  localparam logic [4:0] ADDR_TX_STAT = 5'h0c;
  localparam logic [4:0] ADDR_IRQ_CTRL = 5'h10;

  // ----------------------------------------------------------------
  // receive_status_control fields
  // ----------------------------------------------------------------
  localparam int RS_PORT_EN = 7;
  localparam int RS_NINE = 6;
  localparam int RS_SINGLE = 5;
  localparam int RS_CONT = 4;
  localparam int RS_ADDR_DET = 3;
  localparam int RS_FRAMING_ERROR_FLAG = 2;
  localparam int RS_OVERRUN_ERROR_FLAG = 1;
  localparam int RS_NINTH = 0;
  localparam logic [7:0] RS_WMASK = 8'hf8;
  localparam logic [7:0] RS_RESET = 8'h00;

  // ----------------------------------------------------------------
  // transmit_status_control fields
  // ----------------------------------------------------------------
  localparam int TS_CLK_SRC = 7;
  localparam int TS_NINE = 6;
  localparam int TS_TX_EN = 5;
  localparam int TS_SYNC = 4;
  localparam int TS_HIGH_SPD = 2;
  localparam int TS_SH_EMPTY = 1;
  localparam int TS_NINTH = 0;
  localparam logic [7:0] TS_WMASK = 8'hf5;
  localparam logic [7:0] TS_RESET = 8'h02;

  // ----------------------------------------------------------------
  // irq control fields and misc
  // ----------------------------------------------------------------
  localparam int IC_RX_IE = 0;
  localparam int IC_PERIPH_IE = 1;
  localparam int IC_GLOBAL_IE = 2;
  localparam int IC_RX_AVAIL = 3;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } asrs_rx_st_t;
endpackage

`default_nettype wire

// ===== design/asrs_baud_tick.sv
// asrs_baud_tick: 16x oversample tick from the baud divisor.
// assumes divisor and speed select come from registers on sys_clk.
`default_nettype none

module asrs_baud_tick (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] divisor,
  input wire logic high_speed,
  input wire logic restart,
  output logic tick
);
  typedef struct packed {
    logic [9:0] cnt;
    logic tick;
  } asrs_bt_t;

  asrs_bt_t s_r;
  asrs_bt_t s_nxt;
  logic [9:0] limit;

  // ----------------------------------------------------------------
  // divider: period n+1 (high speed) or 4(n+1) (low speed)
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    limit = high_speed ? {2'b00, divisor} : {divisor, 2'b11};
    s_nxt.tick = 1'b0;
    if (restart) begin
      s_nxt.cnt = 10'h000; // new divisor takes effect at once
    end else if (s_r.cnt >= limit) begin
      s_nxt.cnt = 10'h000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 10'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule // asrs_baud_tick

`default_nettype wire

// ===== design/asrs_top.sv
// asrs_top: asynchronous serial receiver with status, 2-deep fifo,
// overrun and address detection, plus transmit control register.
// assumes an AXI4-Lite master on sys_clk and rx_pin from outside.
//
// What this block does
// R1: rx available while enabled and fifo nonempty
// R2: interrupt needs all three enables set
// R3: framing bit stored per character, oldest shown
// R4: data read pops fifo, next status shown
// R5: port disable clears framing flag, rx-disable not
// R6: framing error raises no interrupt, reception continues
// R7: third complete character sets overrun flag
// R8: overrun blocks new characters; rx-disable clears it
// R9: nine-bit mode; ninth bit of oldest shown
// R10: software reads status before data
// R11: address mode loads only ninth-bit-one characters
// R12: software toggles address enable around messages
// R13: address mode delivers ninth bit always one
// R14: software sets up divisor, enables, then receive
// R15: bit 7 clock master, sync mode only
// R16: bit 4 selects synchronous mode
// R17: bit 2 high speed in async mode
// R18: shifter-empty bit read-only, resets to one
// R19: bits 6,5,0: nine-bit, tx enable, ninth
// R20: receive enables override tx enable in sync
// R21: bit 3 reads zero, ignores writes
// R22: 16x oversample, start midpoint check, silent abort
// R23: data bits majority sampled one tick apart
// R24: stop bit zero marks framing error
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`default_nettype none

module asrs_top (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_pin,
  input wire logic tx_shifter_loaded,
  output logic rx_irq,
  output logic tx_enable_eff,
  output logic clock_master,
  output logic sync_mode,
  output logic high_speed_select,
  output logic tx_nine_bit_select,
  output logic tx_ninth_bit
);
  typedef struct packed {
    logic awrdy;
    logic wrdy;
    logic aw_ok;
    logic w_ok;
    logic [4:0] awaddr;
    logic [7:0] wdata;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [7:0] rcsr;
    logic [7:0] baud;
    logic [7:0] txctl;
    logic [2:0] irqen;
    logic rx1;
    logic rx2;
    logic rxp;
    asrs_pkg::asrs_rx_st_t st;
    logic [3:0] os;
    logic [3:0] bitn;
    logic [1:0] maj;
    logic [8:0] sh;
    logic [1:0][9:0] fd;
    logic rd;
    logic [1:0] cnt;
    logic overrun_error_flag;
    logic irq;
    logic tx_enable;
    logic mst;
    logic restart;
  } asrs_st_t;

  asrs_st_t s_r;
  asrs_st_t s_nxt;
  logic tick;
  logic rx_en;
  logic avail_c;
  logic push_c;
  logic disc_c;
  logic ovr_c;
  logic pop_c;
  logic bit_c;
  logic [9:0] head;
  logic wr_c;

  asrs_baud_tick u_tick (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .divisor(s_r.baud),
    .high_speed(s_r.txctl[asrs_pkg::TS_HIGH_SPD]),
    .restart(s_r.restart),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // derived views of state
  // ----------------------------------------------------------------
  // receiver runs only async with port and continuous enable set
  assign rx_en = s_r.rcsr[asrs_pkg::RS_PORT_EN]
    && s_r.rcsr[asrs_pkg::RS_CONT] && !s_r.txctl[asrs_pkg::TS_SYNC];
  assign avail_c = rx_en && (s_r.cnt != 2'd0); // R1
  assign head = (s_r.cnt != 2'd0) ? s_r.fd[s_r.rd] : 10'h000; // R3
  // free slot; with two held, only a pop frees the head slot
  assign wr_c = s_r.rd ^ (s_r.cnt == 2'd1);
  // majority of the two early samples and the current line level
  assign bit_c = (s_r.maj[0] & s_r.maj[1]) | (s_r.maj[0] & s_r.rx2)
    | (s_r.maj[1] & s_r.rx2); // R23

  // ----------------------------------------------------------------
  // next state: bus slave, registers, receiver, fifo
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    push_c = 1'b0;
    disc_c = 1'b0;
    ovr_c = 1'b0;
    pop_c = 1'b0;
    s_nxt.restart = 1'b0;
    // pin synchroniser; only rx2 and its delayed copy rxp feed logic
    s_nxt.rx1 = rx_pin;
    s_nxt.rx2 = s_r.rx1;
    s_nxt.rxp = s_r.rx2;
    s_nxt.txctl[asrs_pkg::TS_SH_EMPTY] = !tx_shifter_loaded; // R18

    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_r.awrdy) begin
      s_nxt.awrdy = 1'b0;
      s_nxt.aw_ok = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wrdy) begin
      s_nxt.wrdy = 1'b0;
      s_nxt.w_ok = 1'b1;
      s_nxt.wdata = s_axi_wdata[7:0];
      s_nxt.wlane = s_axi_wstrb[0];
    end
    if (s_r.aw_ok && s_r.w_ok && !s_r.bvalid) begin
      s_nxt.aw_ok = 1'b0;
      s_nxt.w_ok = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = asrs_pkg::RESP_OKAY;
      case (s_r.awaddr)
        asrs_pkg::ADDR_RX_DATA: ; // read-only, write ignored
        asrs_pkg::ADDR_RX_STAT: begin
          if (s_r.wlane) begin
            s_nxt.rcsr = (s_r.wdata & asrs_pkg::RS_WMASK)
              | (s_r.rcsr & ~asrs_pkg::RS_WMASK);
          end
        end
        asrs_pkg::ADDR_BAUD: begin
          if (s_r.wlane) begin
            s_nxt.baud = s_r.wdata;
            s_nxt.restart = 1'b1;
          end
        end
        asrs_pkg::ADDR_TX_STAT: begin
          // bit 3 and shifter-empty bit are never stored
          if (s_r.wlane) begin
            s_nxt.txctl = (s_r.wdata & asrs_pkg::TS_WMASK)
              | (s_nxt.txctl & ~asrs_pkg::TS_WMASK); // R21 R18
          end
        end
        asrs_pkg::ADDR_IRQ_CTRL: begin
          if (s_r.wlane) begin
            s_nxt.irqen = s_r.wdata[2:0];
          end
        end
        default: s_nxt.bresp = asrs_pkg::RESP_SLVERR;
      endcase
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.awrdy = 1'b1;
      s_nxt.wrdy = 1'b1;
    end

    // read channel: status is sampled before any pop takes effect
    if (s_axi_arvalid && s_r.arrdy) begin
      s_nxt.arrdy = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = asrs_pkg::RESP_OKAY;
      case (s_axi_araddr)
        asrs_pkg::ADDR_RX_DATA: begin
          s_nxt.rdata = head[7:0];
          pop_c = (s_r.cnt != 2'd0); // R4
        end
        asrs_pkg::ADDR_RX_STAT: begin
          s_nxt.rdata = {s_r.rcsr[7:3], head[9], s_r.overrun_error_flag,
            head[8]}; // R3 R9
        end
        asrs_pkg::ADDR_BAUD: s_nxt.rdata = s_r.baud;
        asrs_pkg::ADDR_TX_STAT: s_nxt.rdata = s_r.txctl;
        asrs_pkg::ADDR_IRQ_CTRL: begin
          s_nxt.rdata = {4'h0, avail_c, s_r.irqen}; // R1
        end
        default: begin
          s_nxt.rdata = 8'h00;
          s_nxt.rresp = asrs_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arrdy = 1'b1;
    end

    // receiver: 16x oversampled frame recovery
    case (s_r.st)
      asrs_pkg::RX_IDLE: begin
        if (!s_r.rx2 && s_r.rxp && rx_en) begin // R22
          s_nxt.st = asrs_pkg::RX_START;
          s_nxt.os = 4'h0;
        end
      end
      asrs_pkg::RX_START: begin
        if (tick) begin
          s_nxt.os = s_r.os + 4'h1;
          if (s_r.os == asrs_pkg::OS_MID) begin
            // glitch on the line: drop it without any flag
            if (s_r.rx2) begin
              s_nxt.st = asrs_pkg::RX_IDLE; // R22
            end else begin
              s_nxt.st = asrs_pkg::RX_DATA;
              s_nxt.os = 4'h0;
              s_nxt.bitn = 4'h0;
            end
          end
        end
      end
      asrs_pkg::RX_DATA, asrs_pkg::RX_STOP: begin
        if (tick) begin
          s_nxt.os = s_r.os + 4'h1;
          if (s_r.os == asrs_pkg::OS_LAST - 4'h2) begin
            s_nxt.maj[0] = s_r.rx2;
          end
          if (s_r.os == asrs_pkg::OS_LAST - 4'h1) begin
            s_nxt.maj[1] = s_r.rx2;
          end
          if (s_r.os == asrs_pkg::OS_LAST) begin
            if (s_r.st == asrs_pkg::RX_DATA) begin
              s_nxt.sh[s_r.bitn] = bit_c; // R23 R9
              s_nxt.bitn = s_r.bitn + 4'h1;
              if (s_r.bitn == (s_r.rcsr[asrs_pkg::RS_NINE] ? 4'h8
                  : 4'h7)) begin
                s_nxt.st = asrs_pkg::RX_STOP;
              end
            end else begin
              s_nxt.st = asrs_pkg::RX_IDLE; // R6
              // address mode drops characters with ninth bit clear
              disc_c = s_r.rcsr[asrs_pkg::RS_NINE]
                && s_r.rcsr[asrs_pkg::RS_ADDR_DET] && !s_r.sh[8];
              if (!disc_c && !s_r.overrun_error_flag) begin // R11 R13 R8
                if (s_r.cnt == 2'd2 && !pop_c) begin
                  ovr_c = 1'b1; // R7
                end else begin
                  push_c = 1'b1;
                end
              end
            end
          end
        end
      end
      default: s_nxt.st = asrs_pkg::RX_IDLE;
    endcase
    if (!rx_en) begin
      s_nxt.st = asrs_pkg::RX_IDLE;
      push_c = 1'b0;
      ovr_c = 1'b0;
    end
    if (!s_r.rcsr[asrs_pkg::RS_NINE]) begin
      s_nxt.sh[8] = 1'b0;
    end

    // fifo update; entry = {framing error, ninth bit, data}
    if (push_c) begin
      s_nxt.fd[wr_c] = {!bit_c, s_r.sh}; // R3 R24
    end
    if (pop_c) begin
      s_nxt.rd = !s_r.rd; // R4
    end
    s_nxt.cnt = s_r.cnt + {1'b0, push_c} - {1'b0, pop_c};

    // overrun: clearing the receive enable clears it, a new event wins
    if (!s_r.rcsr[asrs_pkg::RS_CONT]) begin
      s_nxt.overrun_error_flag = 1'b0; // R8
    end
    if (ovr_c) begin
      s_nxt.overrun_error_flag = 1'b1; // R7
    end

    // port disable resets the receiver: fifo, overrun flag, state and baud counter
    if (!s_r.rcsr[asrs_pkg::RS_PORT_EN]) begin
      s_nxt.cnt = 2'd0; // R5
      s_nxt.rd = 1'b0;
      s_nxt.overrun_error_flag = 1'b0;
      s_nxt.st = asrs_pkg::RX_IDLE;
      s_nxt.restart = 1'b1;
    end

    // only the character flag reaches the interrupt, never errors
    s_nxt.irq = avail_c && (&s_r.irqen); // R2 R6
    s_nxt.tx_enable = s_r.txctl[asrs_pkg::TS_TX_EN]
      && !(s_r.txctl[asrs_pkg::TS_SYNC]
      && (s_r.rcsr[asrs_pkg::RS_SINGLE]
      || s_r.rcsr[asrs_pkg::RS_CONT])); // R20
    s_nxt.mst = s_r.txctl[asrs_pkg::TS_SYNC]
      && s_r.txctl[asrs_pkg::TS_CLK_SRC]; // R15 R16
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.awrdy <= 1'b1;
      s_r.wrdy <= 1'b1;
      s_r.arrdy <= 1'b1;
      s_r.rx1 <= 1'b1;
      s_r.rx2 <= 1'b1;
      s_r.rxp <= 1'b1;
      s_r.rcsr <= asrs_pkg::RS_RESET;
      s_r.baud <= asrs_pkg::BAUD_RESET;
      s_r.txctl <= asrs_pkg::TS_RESET; // R18
      s_r.st <= asrs_pkg::RX_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from state flops
  // ----------------------------------------------------------------
  assign s_axi_awready = s_r.awrdy;
  assign s_axi_wready = s_r.wrdy;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_arready = s_r.arrdy;
  assign s_axi_rdata = {24'h000000, s_r.rdata};
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign rx_irq = s_r.irq;
  assign tx_enable_eff = s_r.tx_enable;
  assign clock_master = s_r.mst;
  assign sync_mode = s_r.txctl[asrs_pkg::TS_SYNC]; // R16
  assign high_speed_select = s_r.txctl[asrs_pkg::TS_HIGH_SPD]; // R17
  assign tx_nine_bit_select = s_r.txctl[asrs_pkg::TS_NINE]; // R19
  assign tx_ninth_bit = s_r.txctl[asrs_pkg::TS_NINTH]; // R19

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  AST_AVAIL_EMPTY: assert property ( // R1
    s_axi_arvalid && s_axi_arready
    && s_axi_araddr == asrs_pkg::ADDR_IRQ_CTRL
    && (s_r.cnt == 2'd0 || !rx_en) |=> !s_axi_rdata[asrs_pkg::IC_RX_AVAIL])
    else $error("avail shown without a character");
  AST_IRQ_GATE: assert property ( // R2
    rx_irq |-> $past(avail_c) && $past(&s_r.irqen))
    else $error("irq without flag and all enables");
  AST_POP_ADVANCE: assert property ( // R4
    pop_c && s_r.cnt == 2'd2 && !push_c && s_r.rcsr[asrs_pkg::RS_PORT_EN]
    |=> s_r.cnt == 2'd1 && s_r.rd != $past(s_r.rd))
    else $error("pop did not advance");
  AST_PORT_ENABLE_CLEARS: assert property ( // R5
    !s_r.rcsr[asrs_pkg::RS_PORT_EN] |=> s_r.cnt == 2'd0 && !s_r.overrun_error_flag)
    else $error("port disable left fifo or overrun");
  AST_OVR_SET: assert property ( // R7
    ovr_c |=> s_r.overrun_error_flag && s_r.cnt == 2'd2)
    else $error("third character did not overrun");
  AST_OVR_BLOCK: assert property ( // R8
    s_r.overrun_error_flag && !pop_c && s_r.rcsr[asrs_pkg::RS_PORT_EN]
    |=> s_r.cnt == $past(s_r.cnt))
    else $error("character accepted during overrun");
  AST_ADDR_ONLY: assert property ( // R11
    push_c && s_r.rcsr[asrs_pkg::RS_NINE]
    && s_r.rcsr[asrs_pkg::RS_ADDR_DET] |=> s_r.fd[$past(wr_c)][8])
    else $error("address mode loaded ninth bit zero");
  AST_TX_PRIO: assert property ( // R20
    s_r.txctl[asrs_pkg::TS_SYNC] && s_r.rcsr[asrs_pkg::RS_CONT]
    ##1 s_r.txctl[asrs_pkg::TS_SYNC] |-> !tx_enable_eff)
    else $error("tx enable not overridden");
  AST_BIT3_ZERO: assert property ( // R21
    s_r.txctl[3] == 1'b0) else $error("tx control bit 3 set");
  AST_START_ABORT: assert property ( // R22
    s_r.st == asrs_pkg::RX_START && tick && s_r.os == asrs_pkg::OS_MID
    && s_r.rx2 && rx_en |=> s_r.st == asrs_pkg::RX_IDLE
    && !$past(push_c)) else $error("false start not dropped");

  COV_PUSH: cover property (push_c);
  COV_OVERRUN: cover property (ovr_c);
  COV_DISCARD: cover property (disc_c);
  COV_POP: cover property (pop_c ##[1:50] push_c);
endmodule // asrs_top

`default_nettype wire

// ===== dv/asrs_line_model.sv
// asrs_line_model: remote asynchronous transmitter on the serial line.
// assumes one bit time is bit_clks sys_clk cycles, BIT_CLKS at start.
`default_nettype none

module asrs_line_model #(
  parameter int BIT_CLKS = 32
) (
  input wire logic sys_clk,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;

  // bench may retune this between frames for a slower baud setting
  int bit_clks = BIT_CLKS;

  // ----------------------------------------------------------------
  // line driver
  // ----------------------------------------------------------------
  // idle high: the line is pulled up whenever no frame is sent
  initial begin
    line = 1'b1;
  end

  // hold one level for n clocks, changed just after each edge
  task automatic hold(input logic v, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      line <= v;
    end
  endtask

  // start, data lsb first, stop, then one idle bit before the next
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    hold(1'b0, bit_clks);
    for (int i = 0; i < nb; i++) begin
      hold(d[i], bit_clks);
    end
    hold(stop, bit_clks);
    hold(1'b1, bit_clks);
  endtask

  // low pulse shorter than half a bit: a false start
  task automatic glitch(input int n);
    hold(1'b0, n);
    hold(1'b1, 2 * bit_clks);
  endtask
endmodule // asrs_line_model

`default_nettype wire

// ===== dv/asrs_top_tb.sv
// asrs_top_tb: register-level tests of the serial receiver block.
// assumes asrs_pkg, asrs_top and asrs_line_model are compiled first.
`default_nettype none

module asrs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [4:0] A_DAT = asrs_pkg::ADDR_RX_DATA;
  localparam logic [4:0] A_RX = asrs_pkg::ADDR_RX_STAT;
  localparam logic [4:0] A_BD = asrs_pkg::ADDR_BAUD;
  localparam logic [4:0] A_TX = asrs_pkg::ADDR_TX_STAT;
  localparam logic [4:0] A_IC = asrs_pkg::ADDR_IRQ_CTRL;
  localparam logic [31:0] ERR = {30'h0, asrs_pkg::RESP_SLVERR};

  logic sys_clk, nrst, awvalid, wvalid, bready, arvalid, rready, loaded;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] strb;
  logic awready, wready, bvalid, arready, rvalid, rx_line, irq;
  logic txe, cm, syn, hs, t9, t9d;
  logic [1:0] bresp, rresp, last_b;
  logic [5:0] outs;
  int err_total, n_compared;

  assign outs = {txe, cm, syn, hs, t9, t9d};

  asrs_top DUT (.sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rx_pin(rx_line), .tx_shifter_loaded(loaded),
    .rx_irq(irq), .tx_enable_eff(txe), .clock_master(cm),
    .sync_mode(syn), .high_speed_select(hs), .tx_nine_bit_select(t9),
    .tx_ninth_bit(t9d));

  asrs_line_model #(.BIT_CLKS(32)) LM (.sys_clk(sys_clk), .line(rx_line));

  // ----------------------------------------------------------------
  // bus tasks and checks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write: both channels offered together, each dropped when taken
  task automatic axw(input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    last_b = bresp;
    if (n >= 200) err_total++;
  endtask

  task automatic axr(input logic [4:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    d = rdata;
    r = rresp;
    if (n >= 200) err_total++;
  endtask

  // read one register and compare its low byte and the response
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d, {24'h0, e});
    chk({30'h0, r}, {30'h0, asrs_pkg::RESP_OKAY});
  endtask

  // let a register write reach the flopped outputs
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic summarize();
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // tests need about 5400 cycles; a hang ends the run far later
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    summarize();
  end

  initial begin : main
    logic [31:0] d;
    logic [1:0] r;
    {nrst, awvalid, wvalid, bready, arvalid, rready, loaded} = 7'h00;
    {awaddr, araddr, wdata} = 42'h0;
    strb = 4'h1;
    err_total = 0;
    n_compared = 0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    // reset values, unmapped place
    rdc(A_RX, 8'h00);
    rdc(A_BD, 8'h00);
    rdc(A_TX, 8'h02);
    rdc(A_IC, 8'h00);
    axr(5'h14, d, r);
    chk({30'h0, r}, ERR);
    chk(d, 32'h0);
    axw(5'h14, 8'hff);
    chk({30'h0, last_b}, ERR);
    // transmit control fields and their outputs
    axw(A_TX, 8'hff);
    rdc(A_TX, 8'hf7);
    cyc(2);
    chk({26'h0, outs}, 32'h3f);
    axw(A_RX, 8'ha0);
    cyc(2);
    chk({26'h0, outs}, 32'h1f);
    axw(A_RX, 8'h90);
    cyc(2);
    chk({26'h0, outs}, 32'h1f);
    axw(A_RX, 8'h00);
    loaded <= 1'b1;
    cyc(3);
    rdc(A_TX, 8'hf5);
    loaded <= 1'b0;
    axw(A_TX, 8'h84);
    cyc(2);
    chk({26'h0, outs}, 32'h04);
    axw(A_TX, 8'h30);
    cyc(2);
    chk({26'h0, outs}, 32'h28);
    strb <= 4'h0;
    axw(A_TX, 8'hff);
    strb <= 4'h1;
    rdc(A_TX, 8'h32);
    // receiver set-up in software order, then one character
    axw(A_BD, 8'h01);
    axw(A_TX, 8'h04);
    axw(A_IC, 8'h07);
    axw(A_RX, 8'h90);
    rdc(A_BD, 8'h01);
    LM.send(9'h0a5, 8, 1'b1);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    rdc(A_IC, 8'h0f);
    // each enable missing in turn keeps the interrupt low
    for (int i = 0; i < 3; i++) begin
      axw(A_IC, 8'h07 ^ (8'h01 << i));
      cyc(2);
      chk({31'h0, irq}, 32'h0);
      rdc(A_IC, (8'h07 ^ (8'h01 << i)) | 8'h08);
    end
    axw(A_IC, 8'h07);
    rdc(A_RX, 8'h90);
    rdc(A_DAT, 8'ha5);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    LM.glitch(8);
    rdc(A_IC, 8'h07);
    // bad stop bit on the first of two characters
    LM.send(9'h03c, 8, 1'b0);
    LM.send(9'h05a, 8, 1'b1);
    rdc(A_RX, 8'h94);
    rdc(A_DAT, 8'h3c);
    rdc(A_RX, 8'h90);
    rdc(A_DAT, 8'h5a);
    // third character overruns, fourth is refused
    LM.send(9'h011, 8, 1'b1);
    LM.send(9'h022, 8, 1'b0);
    LM.send(9'h033, 8, 1'b1);
    rdc(A_RX, 8'h92);
    LM.send(9'h044, 8, 1'b1);
    rdc(A_DAT, 8'h11);
    rdc(A_RX, 8'h96);
    axw(A_RX, 8'h80);
    rdc(A_RX, 8'h84);
    rdc(A_IC, 8'h07);
    axw(A_RX, 8'h90);
    rdc(A_DAT, 8'h22);
    rdc(A_IC, 8'h07);
    // port disable clears a pending framing error
    LM.send(9'h0ee, 8, 1'b0);
    rdc(A_RX, 8'h94);
    axw(A_RX, 8'h00);
    rdc(A_RX, 8'h00);
    axw(A_RX, 8'h90);
    rdc(A_IC, 8'h07);
    // nine-bit reception and address filtering
    axw(A_RX, 8'hd0);
    LM.send(9'h123, 9, 1'b1);
    rdc(A_RX, 8'hd1);
    rdc(A_DAT, 8'h23);
    axw(A_RX, 8'hd8);
    LM.send(9'h055, 9, 1'b1);
    LM.send(9'h166, 9, 1'b1);
    rdc(A_RX, 8'hd9);
    rdc(A_DAT, 8'h66);
    rdc(A_IC, 8'h07);
    axw(A_RX, 8'hd0);
    LM.send(9'h077, 9, 1'b1);
    rdc(A_RX, 8'hd0);
    rdc(A_DAT, 8'h77);
    // low-speed divisor: tick every 4 clocks, so 64 clocks a bit
    axw(A_RX, 8'h90);
    axw(A_TX, 8'h00);
    axw(A_BD, 8'h00);
    LM.bit_clks = 64;
    LM.send(9'h0c3, 8, 1'b1);
    rdc(A_RX, 8'h90);
    rdc(A_DAT, 8'hc3);
    summarize();
  end
endmodule // asrs_top_tb

`default_nettype wire
